/* File: dsp_pkg.sv */
package dsp_pkg;
	localparam int ADDR_W = 25;
	localparam int IO_W = 16;
	localparam logic [15:0] IO_NONPAGE_TIMING = 16'h4072;
	localparam logic [15:0] IO_SHADOW_PROTECT = 16'h6072;
	localparam logic [15:0] IO_HIGH_BOUNDARY = 16'hC072;
	localparam logic [15:0] NONPAGE_RESET = 16'h0000;
	localparam logic [15:0] SHADOW_RESET = 16'h0004;
	localparam logic [15:0] BOUNDARY_RESET = 16'h0000;
	localparam logic [15:0] NONPAGE_RD_MASK = 16'h7F7F;
	localparam logic [15:0] SHADOW_RD_MASK = 16'hFF3F;
	localparam logic [15:0] BOUNDARY_RD_MASK = 16'h00FF;
	// shadow_and_write_protect fields
	localparam int LOWDIS_LSB = 14;
	localparam int HIPROT_BIT = 13;
	localparam int SHPROT_BIT = 12;
	localparam int PARINV_BIT = 11;
	localparam int PAROVR_BIT = 10;
	localparam int SHADOW_LSB = 8;
	localparam int VIDSZ_LSB = 4;
	localparam int PROM_LSB = 2;
	localparam int POINTER_LSB = 0;
	// nonpage_dram_timing fields
	localparam int RASMODE_LSB = 13;
	localparam int RAWDIS_BIT = 12;
	localparam int WRDEL_LSB = 10;
	localparam int RDDEL_LSB = 8;
	localparam int RASHLD_LSB = 5;
	localparam int CASW_LSB = 2;
	localparam int MINWS_LSB = 0;
	localparam logic [1:0] RAS_FROM_STATUS = 2'b11;
	// address map
	localparam logic [ADDR_W-1:0] LOW_TOP = 25'h00A0000;
	localparam logic [ADDR_W-1:0] LOW_128K = 25'h0020000;
	localparam logic [ADDR_W-1:0] LOW_256K = 25'h0040000;
	localparam logic [ADDR_W-1:0] LOW_512K = 25'h0080000;
	localparam logic [ADDR_W-1:0] VIDEO_BASE = 25'h00C0000;
	localparam logic [ADDR_W-1:0] VIDEO_TOP = 25'h00CFFFF;
	localparam logic [ADDR_W-1:0] SEG_E_BASE = 25'h00E0000;
	localparam logic [ADDR_W-1:0] SEG_F_BASE = 25'h00F0000;
	localparam logic [ADDR_W-1:0] SEG_F_TOP = 25'h00FFFFF;
	localparam logic [ADDR_W-1:0] HI_E_BASE = 25'h0FE0000;
	localparam logic [ADDR_W-1:0] HI_F_BASE = 25'h0FF0000;
	localparam logic [ADDR_W-1:0] HI_F_TOP = 25'h0FFFFFF;
	localparam int VID_STEP_LSB = 14;
	// timing, counted in half processor clocks (one clk_i cycle each)
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] HALF_ONE = 5'h02;
	localparam logic [CNT_W-1:0] RAS_PRECHARGE = 5'h06;
	localparam logic [CNT_W-1:0] STATUS_MID = 5'h01;
	localparam int CLK_PERIOD_NS = 50;
	localparam longint BOOST_TIME_MS = 1000;
	localparam longint BOOST_CYCLES = BOOST_TIME_MS * 64'd1000000 / CLK_PERIOD_NS;
	localparam int BOOST_W = 25;
	localparam int TUNE_W = 4;
	localparam logic [TUNE_W-1:0] TUNE_RESET = 4'h1;
	typedef enum logic [2:0] {
		DSP_IDLE = 3'b000,
		DSP_START = 3'b001,
		DSP_ROWCAS = 3'b010,
		DSP_CAS = 3'b011,
		DSP_HOLD = 3'b100
	} dsp_state_e;
endpackage

/* File: dsp_range.sv */
`timescale 1ns/10ps
`default_nettype none
// inclusive address window compare
module dsp_range import dsp_pkg::*; #(
	parameter logic [ADDR_W-1:0] LO = '0,
	parameter logic [ADDR_W-1:0] HI = '0
) (
	input wire logic [ADDR_W-1:0] addr_i,
	output logic hit_o
);
	assign hit_o = (addr_i >= LO) && (addr_i <= HI);
endmodule
`default_nettype wire

/* File: dsp_ctrl.sv */
// Summary of operation
// RULE1: low_memory_disable 01/10/11 disables on-board memory from 512K/256K/128K to 640K.
// RULE2: high_region_protect_enable blocks writes above the high boundary register.
// RULE3: boundary register bits 7..0 hold A24..A17, compared against access address.
// RULE4: shadow protect bit write-protects shadowed BIOS regions in DRAM.
// RULE5: parity_invert makes on-board DRAM writes carry inverted parity.
// RULE6: parity_check_override disables parity checking regardless of port 061.
// RULE7: bios_shadow_select picks none, F segment, E-F segments, or F plus video.
// RULE8: shadow code 11 places video shadow at 0C0000, sized by video_rom_size.
// RULE9: video_rom_size selects a 16K, 32K, 48K or 64K video window.
// RULE10: prom layout 00 selects PROM at 0E0000-0FFFFF and FE0000-FFFFFF.
// RULE11: prom layout 01 selects PROM at 0F0000-0FFFFF and FF0000-FFFFFF.
// RULE12: prom layout 10 adds a video PROM window at 0C0000 sized by video size.
// RULE13: selected pointer interrupt with auto speed on boosts CPU speed one second.
// RULE14: DMA/master strobes use a tuned delay, RAS starts from memory command.
// RULE15: timing register writes take effect immediately.
// RULE16: ras_start_mode 00 starts RAS at once, 11 from status strobe middle.
// RULE17: interleaved same-bank back-to-back access delays RAS for three clocks precharge.
// RULE18: raw_wait_disable 0 adds read-after-write waits, 1 adds none.
// RULE19: CAS delays 1 to 2.5 clocks; codes 01/10 shorten CAS pulse half clock.
// RULE20: RAS hold after CAS 1 to 2.5 clocks, less half for odd delays.
// RULE21: cas_pulse_width selects 1 to 4.5 clocks in half-clock steps.
// RULE22: minimum wait 0-3 plus read +1/+2/+3 and write +1 extras.
// RULE23: writes into enabled protected regions suppress DRAM write strobes.
`timescale 1ns/10ps
`default_nettype none
module dsp_ctrl import dsp_pkg::*; #(
	parameter logic [BOOST_W-1:0] BOOST_COUNT = BOOST_W'(BOOST_CYCLES)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [IO_W-1:0] io_wdata_i,
	output logic [IO_W-1:0] io_rdata_o,
	input wire logic [ADDR_W-1:0] mem_addr_i,
	input wire logic status_strobe_zero_n_i,
	input wire logic status_strobe_one_n_i,
	input wire logic memory_read_command_n_i,
	input wire logic memory_write_command_n_i,
	input wire logic dma_cycle_i,
	input wire logic dram_select_i,
	input wire logic [1:0] bank_i,
	input wire logic interleave_i,
	input wire logic ems_interleave_wait_i,
	input wire logic port061_parity_enable_i,
	input wire logic delay_reference_clock_i,
	input wire logic auto_speed_enable_i,
	input wire logic irq12_i,
	input wire logic irq4_i,
	input wire logic irq3_i,
	output logic onboard_enable_o,
	output logic shadow_hit_o,
	output logic write_protect_hit_o,
	output logic dram_write_enable_o,
	output logic parity_invert_o,
	output logic parity_check_enable_o,
	output logic prom_chip_select_o,
	output logic speed_boost_o,
	output logic ras_o,
	output logic cas_o,
	output logic [2:0] wait_states_o
);
	typedef struct packed {
		logic [15:0] nonpage;
		logic [15:0] shadow;
		logic [15:0] bound;
		logic [IO_W-1:0] rdata;
		dsp_state_e state;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] pre;
		logic [1:0] last_bank;
		logic last_write;
		logic cur_write;
		logic [2:0] ws;
		logic ras;
		logic cas;
		logic strobe_prev;
		logic cmd_prev;
		logic [2:0] irq_prev;
		logic [BOOST_W-1:0] boost;
		logic ref_prev;
		logic [TUNE_W-1:0] tune_cnt;
		logic [TUNE_W-1:0] tune;
	} dsp_state_s;

	dsp_state_s st_q, st_d;

	logic hit_low, hit_vid, hit_e, hit_f, hit_hi_e, hit_hi_f, vid_in;
	logic shadow_hit, hi_hit, prot_hit, rom_hit, is_write, strobe_act, cmd_act;
	logic [1:0] lowdis, bios_shadow_select, vsz, prom, mode, wrdel, rddel, hld, minws, del;
	logic [2:0] casw;
	logic [ADDR_W-1:0] low_lo;
	logic [CNT_W-1:0] rcd_len, cas_len, hold_len, start_len;
	logic [2:0] sel_irq;
	logic cyc_start;

	dsp_range #(.LO(LOW_128K), .HI(LOW_TOP - 25'h1)) u_low (
		.addr_i(mem_addr_i),
		.hit_o(hit_low)
	);
	dsp_range #(.LO(VIDEO_BASE), .HI(VIDEO_TOP)) u_vid (.addr_i(mem_addr_i), .hit_o(hit_vid));
	dsp_range #(.LO(SEG_E_BASE), .HI(SEG_F_TOP)) u_e (.addr_i(mem_addr_i), .hit_o(hit_e));
	dsp_range #(.LO(SEG_F_BASE), .HI(SEG_F_TOP)) u_f (.addr_i(mem_addr_i), .hit_o(hit_f));
	dsp_range #(.LO(HI_E_BASE), .HI(HI_F_TOP)) u_he (.addr_i(mem_addr_i), .hit_o(hit_hi_e));
	dsp_range #(.LO(HI_F_BASE), .HI(HI_F_TOP)) u_hf (.addr_i(mem_addr_i), .hit_o(hit_hi_f));

	always_comb begin
		lowdis = st_q.shadow[LOWDIS_LSB +: 2];
		bios_shadow_select = st_q.shadow[SHADOW_LSB +: 2];
		vsz = st_q.shadow[VIDSZ_LSB +: 2];
		prom = st_q.shadow[PROM_LSB +: 2];
		mode = st_q.nonpage[RASMODE_LSB +: 2];
		wrdel = st_q.nonpage[WRDEL_LSB +: 2];
		rddel = st_q.nonpage[RDDEL_LSB +: 2];
		hld = st_q.nonpage[RASHLD_LSB +: 2];
		casw = st_q.nonpage[CASW_LSB +: 3];
		minws = st_q.nonpage[MINWS_LSB +: 2];
		is_write = ~status_strobe_zero_n_i | ~memory_write_command_n_i;
		// low memory disable limit
		case (lowdis) // RULE1
			2'b01: low_lo = LOW_512K;
			2'b10: low_lo = LOW_256K;
			2'b11: low_lo = LOW_128K;
			default: low_lo = LOW_TOP;
		endcase
		onboard_enable_o = ~(hit_low && (mem_addr_i >= low_lo)); // RULE1
		// video window top follows the size field in 16K steps
		vid_in = hit_vid && (mem_addr_i[VID_STEP_LSB +: 2] <= vsz); // RULE9
		case (bios_shadow_select) // RULE7
			2'b01: shadow_hit = hit_f;
			2'b10: shadow_hit = hit_e;
			2'b11: shadow_hit = hit_f | vid_in; // RULE8
			default: shadow_hit = 1'b0;
		endcase
		hi_hit = mem_addr_i[ADDR_W-1:17] > st_q.bound[7:0]; // RULE3
		prot_hit = (st_q.shadow[HIPROT_BIT] & hi_hit) // RULE2
			| (st_q.shadow[SHPROT_BIT] & shadow_hit); // RULE4
		case (prom)
			2'b00: rom_hit = hit_e | hit_hi_e; // RULE10
			2'b01: rom_hit = hit_f | hit_hi_f; // RULE11
			2'b10: rom_hit = hit_f | hit_hi_f | vid_in; // RULE12
			default: rom_hit = 1'b0;
		endcase
		// shadowed copies are served from DRAM; top-of-space ROM never shadows
		prom_chip_select_o = rom_hit & ~(shadow_hit & ~hit_hi_e);
		shadow_hit_o = shadow_hit;
		write_protect_hit_o = prot_hit;
		dram_write_enable_o = is_write & dram_select_i & ~prot_hit; // RULE23
		parity_invert_o = st_q.shadow[PARINV_BIT]; // RULE5
		parity_check_enable_o = port061_parity_enable_i & ~st_q.shadow[PAROVR_BIT]; // RULE6
		case (st_q.shadow[POINTER_LSB +: 2]) // RULE13
			2'b01: sel_irq = 3'b001;
			2'b10: sel_irq = 3'b010;
			2'b11: sel_irq = 3'b100;
			default: sel_irq = 3'b000;
		endcase
		speed_boost_o = (st_q.boost != '0) & auto_speed_enable_i; // RULE13
		ras_o = st_q.ras;
		cas_o = st_q.cas;
		wait_states_o = st_q.ws;
		io_rdata_o = st_q.rdata;
	end

	always_comb begin
		st_d = st_q;
		strobe_act = ~status_strobe_zero_n_i | ~status_strobe_one_n_i;
		cmd_act = ~memory_read_command_n_i | ~memory_write_command_n_i;
		// register port: writes act on the next edge
		if (io_wr_i) begin
			case (io_addr_i)
				IO_NONPAGE_TIMING: st_d.nonpage = io_wdata_i & NONPAGE_RD_MASK; // RULE15
				IO_SHADOW_PROTECT: st_d.shadow = io_wdata_i & SHADOW_RD_MASK;
				IO_HIGH_BOUNDARY: st_d.bound = io_wdata_i & BOUNDARY_RD_MASK; // RULE3
				default: ;
			endcase
		end
		if (io_rd_i) begin
			case (io_addr_i)
				IO_NONPAGE_TIMING: st_d.rdata = st_q.nonpage;
				IO_SHADOW_PROTECT: st_d.rdata = st_q.shadow;
				IO_HIGH_BOUNDARY: st_d.rdata = st_q.bound;
				default: st_d.rdata = '0;
			endcase
		end
		// pointer speed-up timer restarts on each selected interrupt edge
		st_d.irq_prev = {irq3_i, irq4_i, irq12_i};
		if (|(sel_irq & {irq3_i, irq4_i, irq12_i} & ~st_q.irq_prev)) begin
			st_d.boost = BOOST_COUNT; // RULE13
		end else if (st_q.boost != '0) begin
			st_d.boost = st_q.boost - BOOST_W'(1);
		end
		// self-tuned delay: clk_i cycles per reference period
		st_d.ref_prev = delay_reference_clock_i;
		if (delay_reference_clock_i & ~st_q.ref_prev) begin
			st_d.tune = (st_q.tune_cnt == '0) ? TUNE_RESET : st_q.tune_cnt; // RULE14
			st_d.tune_cnt = '0;
		end else if (st_q.tune_cnt != '1) begin
			st_d.tune_cnt = st_q.tune_cnt + TUNE_W'(1);
		end
		// strobe lengths in half clocks
		del = is_write ? wrdel : rddel;
		rcd_len = HALF_ONE + CNT_W'(del); // RULE19
		cas_len = HALF_ONE + CNT_W'(casw) - CNT_W'(del == 2'b01 || del == 2'b10); // RULE21 RULE19
		hold_len = HALF_ONE + CNT_W'(hld) - CNT_W'(del[0]); // RULE20
		if (dma_cycle_i) begin
			start_len = CNT_W'(st_q.tune); // RULE14
		end else if (mode == RAS_FROM_STATUS) begin
			start_len = STATUS_MID; // RULE16
		end else begin
			start_len = '0; // RULE16
		end
		// only a pending precharge may stretch the start; the remainder must not wrap
		if (interleave_i && bank_i == st_q.last_bank && st_q.pre < RAS_PRECHARGE
			&& (RAS_PRECHARGE - st_q.pre) > start_len) begin
			start_len = RAS_PRECHARGE - st_q.pre; // RULE17
		end
		st_d.strobe_prev = strobe_act;
		st_d.cmd_prev = cmd_act;
		cyc_start = dram_select_i && (dma_cycle_i ? (cmd_act & ~st_q.cmd_prev) // RULE14
			: (strobe_act & ~st_q.strobe_prev));
		if (!st_q.ras && st_q.pre != '1) begin
			st_d.pre = st_q.pre + CNT_W'(1);
		end
		case (st_q.state)
			DSP_IDLE: begin
				if (cyc_start) begin
					st_d.cur_write = is_write;
					st_d.ws = {1'b0, minws}; // RULE22
					if (!is_write && st_q.last_write && !st_q.nonpage[RAWDIS_BIT]) begin
						st_d.ws = st_d.ws + 3'h1; // RULE18 RULE22
					end
					if (ems_interleave_wait_i) begin
						st_d.ws = st_d.ws + (is_write ? 3'h1 : 3'h2); // RULE22
					end
					st_d.cnt = start_len;
					st_d.state = DSP_START;
				end
			end
			DSP_START: begin
				if (st_q.cnt == '0) begin
					st_d.ras = 1'b1;
					st_d.last_bank = bank_i;
					st_d.cnt = rcd_len - CNT_W'(1);
					st_d.state = DSP_ROWCAS;
				end else begin
					st_d.cnt = st_q.cnt - CNT_W'(1);
				end
			end
			DSP_ROWCAS: begin
				if (st_q.cnt == '0) begin
					st_d.cas = 1'b1;
					st_d.cnt = cas_len - CNT_W'(1);
					st_d.state = DSP_CAS;
				end else begin
					st_d.cnt = st_q.cnt - CNT_W'(1);
				end
			end
			DSP_CAS: begin
				if (st_q.cnt == '0) begin
					st_d.cas = 1'b0;
					st_d.cnt = hold_len - CNT_W'(1);
					st_d.state = DSP_HOLD;
				end else begin
					st_d.cnt = st_q.cnt - CNT_W'(1);
				end
			end
			DSP_HOLD: begin
				if (st_q.cnt == '0) begin
					st_d.ras = 1'b0;
					st_d.pre = '0;
					st_d.last_write = st_q.cur_write;
					st_d.state = DSP_IDLE;
				end else begin
					st_d.cnt = st_q.cnt - CNT_W'(1);
				end
			end
			default: begin
				st_d.state = DSP_IDLE;
				st_d.ras = 1'b0;
				st_d.cas = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
			st_q.nonpage <= NONPAGE_RESET;
			st_q.shadow <= SHADOW_RESET;
			st_q.bound <= BOUNDARY_RESET;
			st_q.state <= DSP_IDLE;
			st_q.pre <= RAS_PRECHARGE;
			st_q.tune <= TUNE_RESET;
		end else begin
			st_q <= st_d;
		end
	end
endmodule
`default_nettype wire

/* File: dsp_ctrl_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module dsp_ctrl_assertions import dsp_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic [IO_W-1:0] io_wdata_i,
	input wire logic [ADDR_W-1:0] mem_addr_i,
	input wire logic dma_cycle_i,
	input wire logic port061_parity_enable_i,
	input wire logic auto_speed_enable_i,
	input wire logic onboard_enable_o,
	input wire logic write_protect_hit_o,
	input wire logic dram_write_enable_o,
	input wire logic parity_invert_o,
	input wire logic parity_check_enable_o,
	input wire logic prom_chip_select_o,
	input wire logic speed_boost_o,
	input wire logic ras_o,
	input wire logic cas_o
);
	logic [15:0] sh_q, np_q, bd_q;
	logic [4:0] rc_q, cc_q, hc_q;
	logic [ADDR_W-1:0] lo;
	logic [1:0] dl;
	logic same;
	assign lo = sh_q[15] ? (sh_q[14] ? LOW_128K : LOW_256K) : LOW_512K;
	assign dl = np_q[9:8];
	assign same = np_q[11:10] == dl && !dma_cycle_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// shadow copies of the registers and strobe phase counters
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sh_q <= SHADOW_RESET;
			np_q <= NONPAGE_RESET;
			bd_q <= BOUNDARY_RESET;
		end else if (io_wr_i) begin
			if (io_addr_i == IO_SHADOW_PROTECT) sh_q <= io_wdata_i & SHADOW_RD_MASK;
			if (io_addr_i == IO_NONPAGE_TIMING) np_q <= io_wdata_i & NONPAGE_RD_MASK;
			if (io_addr_i == IO_HIGH_BOUNDARY) bd_q <= io_wdata_i & BOUNDARY_RD_MASK;
		end
		rc_q <= ras_o ? rc_q + 5'h01 : 5'h00;
		cc_q <= cas_o ? cc_q + 5'h01 : 5'h00;
		hc_q <= (ras_o && !cas_o) ? hc_q + 5'h01 : 5'h00;
	end
	sequence cas_up;
		$rose(cas_o) && same;
	endsequence
	a_low_disable: assert property (sh_q[15:14] != 2'h0 && mem_addr_i >= lo
		&& mem_addr_i < LOW_TOP |-> !onboard_enable_o) else $error("low memory enabled");
	a_high_protect: assert property (sh_q[HIPROT_BIT] && mem_addr_i[24:17] > bd_q[7:0]
		|-> write_protect_hit_o) else $error("high region open");
	a_shadow_protect: assert property (sh_q[12:8] == 5'h11 && mem_addr_i >= SEG_F_BASE
		&& mem_addr_i <= SEG_F_TOP |-> write_protect_hit_o) else $error("shadow open");
	a_write_gate: assert property (dram_write_enable_o |-> !write_protect_hit_o)
		else $error("write strobe in protected region");
	a_parity_invert: assert property (parity_invert_o == sh_q[PARINV_BIT])
		else $error("parity invert wrong");
	a_parity_check: assert property (parity_check_enable_o ==
		(port061_parity_enable_i && !sh_q[PAROVR_BIT])) else $error("parity check wrong");
	a_prom_top: assert property (sh_q[3:2] != 2'h3 && mem_addr_i <= HI_F_TOP
		&& mem_addr_i >= (sh_q[3:2] == 2'h0 ? HI_E_BASE : HI_F_BASE) |-> prom_chip_select_o)
		else $error("prom select missing");
	a_boost_gate: assert property (speed_boost_o |-> auto_speed_enable_i)
		else $error("boost without auto");
	a_cas_delay: assert property (cas_up |-> rc_q == 5'h02 + dl)
		else $error("cas delay wrong");
	a_cas_width: assert property ($fell(cas_o) && same |->
		cc_q == 5'h02 + np_q[4:2] - (dl == 2'h1 || dl == 2'h2)) else $error("cas width wrong");
	a_ras_hold: assert property ($fell(ras_o) && same |-> hc_q == 5'h02 + np_q[6:5] - dl[0])
		else $error("ras hold wrong");
endmodule
bind dsp_ctrl dsp_ctrl_assertions i_dsp_ctrl_assertions (.clk_i(clk_i), .rst_i(rst_i),
	.io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .mem_addr_i(mem_addr_i),
	.dma_cycle_i(dma_cycle_i), .port061_parity_enable_i(port061_parity_enable_i),
	.auto_speed_enable_i(auto_speed_enable_i), .onboard_enable_o(onboard_enable_o),
	.write_protect_hit_o(write_protect_hit_o), .dram_write_enable_o(dram_write_enable_o),
	.parity_invert_o(parity_invert_o), .parity_check_enable_o(parity_check_enable_o),
	.prom_chip_select_o(prom_chip_select_o), .speed_boost_o(speed_boost_o),
	.ras_o(ras_o), .cas_o(cas_o));
`default_nettype wire

/* File: dsp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dsp_host_model import dsp_pkg::*; (
	input wire logic clk_i,
	input wire logic ras_i,
	output logic [ADDR_W-1:0] addr_o,
	output logic status_strobe_zero_n_o,
	output logic status_strobe_one_n_o,
	output logic memory_read_command_n_o,
	output logic memory_write_command_n_o,
	output logic dma_o,
	output logic sel_o
);
	initial {addr_o, status_strobe_zero_n_o, status_strobe_one_n_o, memory_read_command_n_o,
		memory_write_command_n_o, dma_o, sel_o} = {25'h0000000, 6'h3C};
	task automatic put(input logic [ADDR_W-1:0] a);
		addr_o = a;
	endtask
	// one memory cycle; ends a clock after ras has fallen
	task automatic access(input logic [ADDR_W-1:0] a, input logic wr, input logic dma);
		logic seen;
		seen = 1'b0;
		@(negedge clk_i);
		{addr_o, sel_o, dma_o} = {a, 1'b1, dma};
		{status_strobe_zero_n_o, status_strobe_one_n_o} = {dma | !wr, dma | wr};
		{memory_write_command_n_o, memory_read_command_n_o} = {!wr, wr};
		repeat (2) @(negedge clk_i);
		{status_strobe_zero_n_o, status_strobe_one_n_o} = 2'h3;
		for (int i = 0; i < 60 && !(seen && !ras_i); i++) begin
			seen |= ras_i;
			@(negedge clk_i);
		end
		@(negedge clk_i);
		{memory_read_command_n_o, memory_write_command_n_o, dma_o, sel_o} = 4'hC;
		addr_o = ~a;
	endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench import dsp_pkg::*;;
	logic clk_i, rst_i, io_wr, io_rd, ilv, ems, p061, refc, auto, irq12, irq4, irq3;
	logic [15:0] io_addr, io_wdata, io_rdata;
	logic [1:0] bank;
	logic [24:0] addr;
	logic stz_n, sto_n, mrd_n, mwr_n, dma, sel, onb, shh, wph, dwe, pinv, pchk, prom, boost;
	logic ras, cas, we_seen, ras_seen;
	logic [2:0] ws;
	logic [4:0] lowc, gap;
	int errors, total_checks;
	dsp_ctrl #(.BOOST_COUNT(25'h0000014)) i_dsp_ctrl (.clk_i(clk_i), .rst_i(rst_i),
		.io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
		.io_rdata_o(io_rdata), .mem_addr_i(addr), .status_strobe_zero_n_i(stz_n),
		.status_strobe_one_n_i(sto_n), .memory_read_command_n_i(mrd_n),
		.memory_write_command_n_i(mwr_n), .dma_cycle_i(dma), .dram_select_i(sel), .bank_i(bank),
		.interleave_i(ilv), .ems_interleave_wait_i(ems), .port061_parity_enable_i(p061),
		.delay_reference_clock_i(refc), .auto_speed_enable_i(auto), .irq12_i(irq12),
		.irq4_i(irq4), .irq3_i(irq3), .onboard_enable_o(onb), .shadow_hit_o(shh),
		.write_protect_hit_o(wph), .dram_write_enable_o(dwe), .parity_invert_o(pinv),
		.parity_check_enable_o(pchk), .prom_chip_select_o(prom), .speed_boost_o(boost),
		.ras_o(ras), .cas_o(cas), .wait_states_o(ws));
	dsp_host_model i_dsp_host_model (.clk_i(clk_i), .ras_i(ras), .addr_o(addr),
		.status_strobe_zero_n_o(stz_n), .status_strobe_one_n_o(sto_n),
		.memory_read_command_n_o(mrd_n), .memory_write_command_n_o(mwr_n), .dma_o(dma), .sel_o(sel));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		refc = 1'b0;
		forever #34.92 refc = ~refc;
	end
	// ras low time before each rise, for the precharge check
	always @(posedge clk_i) begin
		if (dwe) we_seen <= 1'b1;
		if (ras) ras_seen <= 1'b1;
		if (ras && lowc != 5'h00) gap <= lowc;
		lowc <= ras ? 5'h00 : (lowc == 5'h1F ? lowc : lowc + 5'h01);
	end
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#1000000;
		errors++;
		close_out;
	end
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk_i);
		{io_addr, io_wdata, io_wr} = {a, d, 1'b1};
		@(negedge clk_i);
		io_wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(negedge clk_i);
		{io_addr, io_rd} = {a, 1'b1};
		@(negedge clk_i);
		io_rd = 1'b0;
		@(negedge clk_i);
		chk("read data", io_rdata, e);
	endtask
	task automatic pr(input logic [24:0] a);
		@(negedge clk_i);
		i_dsp_host_model.put(a);
		#1;
	endtask
	task automatic cyc(input logic [24:0] a, input logic w, input logic d);
		{we_seen, ras_seen} = 2'h0;
		i_dsp_host_model.access(a, w, d);
	endtask
	task automatic t_regs;
		logic [15:0] ad [3] = '{IO_NONPAGE_TIMING, IO_SHADOW_PROTECT, IO_HIGH_BOUNDARY};
		logic [15:0] rv [3] = '{NONPAGE_RESET, SHADOW_RESET, 16'h0000};
		logic [15:0] mk [3] = '{16'h7F7F, 16'hFF3F, 16'h00FF};
		for (int i = 0; i < 3; i++) begin
			rd(ad[i], rv[i]);
			wr(ad[i], 16'hFFFF);
			rd(ad[i], mk[i]);
		end
		wr(16'h1072, 16'hFFFF);
		rd(16'h1072, 16'h0000);
	endtask
	task automatic t_map;
		logic [24:0] lo [4] = '{LOW_128K, LOW_512K, LOW_256K, LOW_128K};
		logic [24:0] pa [6] = '{25'hE8000, 25'hF8000, 25'hFE8000, 25'hFF8000, 25'hC2000, 25'hC6000};
		logic [5:0] pe [3] = '{6'h0F, 6'h0A, 6'h1A};
		for (int c = 0; c < 4; c++) begin
			wr(IO_SHADOW_PROTECT, 16'(c << 14));
			pr(lo[c]);
			chk("onboard", onb, 16'(c == 0));
			pr(lo[c] - 25'h1);
			chk("onboard below", onb, 16'h1);
			wr(IO_SHADOW_PROTECT, 16'(c << 8));
			pr(c == 2 ? SEG_E_BASE : SEG_F_BASE);
			chk("shadow base", shh, 16'(c != 0));
			pr(SEG_E_BASE + 25'hFFFF - (c == 2 ? 25'h10000 : 25'h0));
			chk("below shadow", shh, 16'h0);
			wr(IO_SHADOW_PROTECT, 16'(16'h0300 | c << 4));
			pr(VIDEO_BASE + 25'((c + 1) << 14) - 25'h1);
			chk("video top", shh, 16'h1);
			pr(VIDEO_BASE + 25'((c + 1) << 14));
			chk("video end", shh, 16'h0);
		end
		for (int l = 0; l < 3; l++) begin
			wr(IO_SHADOW_PROTECT, 16'(l << 2));
			for (int j = 0; j < 6; j++) begin
				pr(pa[j]);
				chk("prom select", prom, 16'(pe[l][j]));
			end
		end
	endtask
	task automatic t_prot;
		wr(IO_HIGH_BOUNDARY, 16'h0008);
		wr(IO_SHADOW_PROTECT, 16'h2C00);
		chk("parity invert", pinv, 16'h1);
		chk("check override", pchk, 16'h0);
		pr(25'h0120000);
		chk("above bound", wph, 16'h1);
		pr(25'h011FFFF);
		chk("at bound", wph, 16'h0);
		cyc(25'h0120000, 1'b1, 1'b0);
		chk("blocked write", we_seen, 16'h0);
		cyc(25'h0120000, 1'b0, 1'b0);
		chk("protected read", ras_seen, 16'h1);
		cyc(25'h0110000, 1'b1, 1'b0);
		chk("open write", we_seen, 16'h1);
		wr(IO_SHADOW_PROTECT, 16'h0100);
		chk("parity normal", {pinv, pchk}, 16'h1);
		pr(25'h00F8000);
		chk("shadow open", wph, 16'h0);
		wr(IO_SHADOW_PROTECT, 16'h1100);
		chk("shadow shut", wph, 16'h1);
	endtask
	task automatic t_boost;
		for (int c = 1; c < 5; c++) begin
			wr(IO_SHADOW_PROTECT, 16'(c & 3));
			{irq12, irq4, irq3} = 3'(8 >> c);
			repeat (3) @(negedge clk_i);
			chk("boost on", boost, 16'(c < 4));
			{irq12, irq4, irq3} = 3'h0;
			repeat (25) @(negedge clk_i);
			chk("boost off", boost, 16'h0);
		end
	endtask
	task automatic t_timing;
		logic [15:0] cf [6] = '{16'h0000, 16'h052C, 16'h0A7C, 16'h0F44, 16'h6A7C, 16'h0A7C};
		for (int i = 0; i < 6; i++) begin
			wr(IO_NONPAGE_TIMING, cf[i]);
			cyc(25'h0010000, 1'b0, i == 5);
			chk("read ras", ras_seen, 16'h1);
			cyc(25'h0010000, 1'b1, 1'b0);
			chk("write ras", ras_seen, 16'h1);
		end
	endtask
	task automatic t_wait;
		logic [15:0] wc [3] = '{16'h0002, 16'h0002, 16'h1003};
		logic [2:0] we [3] = '{3'h5, 3'h3, 3'h3};
		for (int i = 0; i < 3; i++) begin
			ems = i == 0;
			wr(IO_NONPAGE_TIMING, wc[i]);
			cyc(25'h0010000, 1'b1, 1'b0);
			chk("write waits", ws, 16'(wc[i][1:0] + ems));
			cyc(25'h0010000, 1'b0, 1'b0);
			chk("read waits", ws, 16'(we[i]));
		end
		ems = 1'b0;
		ilv = 1'b1;
		cyc(25'h0010000, 1'b0, 1'b0);
		cyc(25'h0010000, 1'b0, 1'b0);
		chk("precharge", 16'(gap >= 5'h06), 16'h1);
	endtask
	initial begin
		{rst_i, io_wr, io_rd, ilv, ems, p061, auto, irq12, irq4, irq3} = 10'h218;
		{io_addr, io_wdata, bank, errors, total_checks} = '0;
		{we_seen, ras_seen, lowc, gap} = '0;
		repeat (20) @(negedge clk_i);
		rst_i = 1'b0;
		t_regs;
		t_map;
		t_prot;
		t_boost;
		auto = 1'b0;
		t_timing;
		t_wait;
		close_out;
	end
endmodule
`default_nettype wire
